// file: common/aess_pkg.sv
package aess_pkg;

	// page size that one frame-size unit stands for
	localparam int unsigned PAGE_SHIFT = 12;
	localparam int unsigned ADDR_W = 64;
	localparam int unsigned SLOT_W = 32;
	localparam int unsigned NUM_UPPER = 8;

	// accumulator value on exit: leaf index of the resume command
	localparam logic [63:0] RESUME_LEAF = 64'h0000_0000_0000_0003;
	localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;
	localparam logic [63:0] LOW32_MASK = 64'h0000_0000_ffff_ffff;

	// flag bit positions cleared by an exit
	localparam int unsigned CARRY_BIT = 0;
	localparam int unsigned PARITY_BIT = 2;
	localparam int unsigned ADJUST_BIT = 4;
	localparam int unsigned ZERO_BIT = 6;
	localparam int unsigned SIGN_BIT = 7;
	localparam int unsigned OVERFLOW_BIT = 11;
	localparam int unsigned RESUME_BIT = 16;
	localparam logic [63:0] FLAGS_CLEAR_MASK = (64'h1 << CARRY_BIT) | (64'h1 << PARITY_BIT)
		| (64'h1 << ADJUST_BIT) | (64'h1 << ZERO_BIT) | (64'h1 << SIGN_BIT)
		| (64'h1 << OVERFLOW_BIT) | (64'h1 << RESUME_BIT);

	// synthetic floating-point control values
	localparam logic [15:0] X87_CW_FAULT = 16'h037e;
	localparam logic [15:0] X87_CW_OTHER = 16'h037f;
	localparam logic [15:0] X87_SW_FAULT = 16'h8081;
	localparam logic [15:0] X87_SW_OTHER = 16'h0000;
	localparam logic [31:0] SIMD_CS_FAULT = 32'h0000_1f01;
	localparam logic [31:0] SIMD_CS_OTHER = 32'h0000_1fb0;
	// init state: mask bits 1:0 set, header bits 1:0 clear
	localparam logic [1:0] INIT_FEATURE_MASK = 2'h3;
	localparam logic [1:0] INIT_HEADER_VECTOR = 2'h0;

	// low bits of the fault address cleared on a page fault exit
	localparam logic [63:0] FAULT_LOW_MASK = 64'hffff_ffff_ffff_f000;

	// general register file image
	typedef struct packed {
		logic [63:0] accumulator_reg;
		logic [63:0] base_reg;
		logic [63:0] counter_reg;
		logic [63:0] data_reg;
		logic [63:0] source_index_reg;
		logic [63:0] dest_index_reg;
		logic [63:0] stack_pointer_reg;
		logic [63:0] frame_base_reg;
		logic [NUM_UPPER-1:0][63:0] upper_general_regs;
		logic [63:0] instruction_pointer;
		logic [63:0] flags_reg;
	} aess_gpr_t;

	// what caused the exit
	typedef struct packed {
		logic x87_fp_fault;
		logic simd_fp_fault;
		logic page_fault;
		logic pf_vm_exit;
		logic pf_in_delivery;
	} aess_cause_t;

	// segment bases
	typedef struct packed {
		logic [63:0] extra_segment_one;
		logic [63:0] extra_segment_two;
	} aess_seg_t;

	// synthetic floating-point state
	typedef struct packed {
		logic [15:0] x87_control_word;
		logic [15:0] x87_status_word;
		logic [31:0] simd_ctrl_status;
		logic [1:0] requested_feature_mask;
		logic [1:0] header_state_vector;
	} aess_fp_t;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAVE,
		ST_SYNTH
	} aess_state_t;

endpackage

// file: rtl/aess_frame_addr.sv
`timescale 1ns/100ps
module aess_frame_addr #(
	parameter int unsigned SLOT_W = 32
) (
	// enclave and thread geometry
	input wire logic [63:0] enclave_base_linear,
	input wire logic [63:0] save_area_offset,
	input wire logic [SLOT_W-1:0] frame_size_pages,
	input wire logic [SLOT_W-1:0] slot,
	// selected frame
	output logic [63:0] stack_base,
	output logic [63:0] frame_addr
);

	// full-width product so large geometries do not wrap early
	logic [2*SLOT_W-1:0] page_count;
	logic [63:0] byte_offset;

	assign stack_base = enclave_base_linear + save_area_offset;

	assign page_count = (2*SLOT_W)'(slot) * (2*SLOT_W)'(frame_size_pages);
	assign byte_offset = 64'(page_count) << aess_pkg::PAGE_SHIFT;

	assign frame_addr = stack_base + byte_offset;

endmodule // aess_frame_addr

// file: rtl/aess_top.sv
// What this block does
// - frame size counts 4-KByte pages
// - stack base is enclave base plus offset
// - slot count total, current slot next
// - exit saves, loads synthetic, increments slot
// - stack and frame pointers from frame
// - resume restores frame below current, frees it
// - extended save uses standard image format
// - enter needs current slot below count
// - low 32 bits or all 64
// - accumulator gets resume leaf three
// - base register gets thread control address
// - counter and instruction pointer get exit pointer
// - zero data, index, upper regs in 64-bit
// - clear seven status flags, keep others
// - floating state goes to init state
// - x87 control word by fault kind
// - x87 status word by fault kind
// - simd control status by fault kind
// - page fault clears low 12 address bits
// - page fault to vm exit keeps address
// - fault during delivery keeps address
// - segment bases from last enter/resume
`timescale 1ns/100ps
module aess_top #(
	parameter int unsigned SLOT_W = aess_pkg::SLOT_W
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// enclave and thread configuration
	input wire logic [63:0] ENCLAVE_BASE_LINEAR,
	input wire logic [SLOT_W-1:0] FRAME_SIZE_PAGES,
	input wire logic [63:0] SAVE_AREA_OFFSET,
	input wire logic [SLOT_W-1:0] SLOT_COUNT,
	input wire logic [63:0] THREAD_CONTROL_STRUCT,
	input wire logic [63:0] ASYNC_EXIT_POINTER,
	// commands
	input wire logic ENTER_REQ,
	input wire logic RESUME_REQ,
	input wire logic EXIT_REQ,
	input wire aess_pkg::aess_cause_t EXIT_CAUSE,
	input wire logic MODE64,
	// live processor state
	input wire aess_pkg::aess_gpr_t GPR_IN,
	input wire aess_pkg::aess_seg_t SEG_IN,
	input wire logic [63:0] FAULT_ADDR_IN,
	// untrusted pointers read back from the frame
	input wire logic [63:0] SAVED_UNTRUSTED_SP,
	input wire logic [63:0] SAVED_UNTRUSTED_BP,
	// command answers
	output logic ENTER_OK,
	output logic ENTER_FAIL,
	output logic RESUME_OK,
	output logic RESUME_FAIL,
	output logic BUSY,
	output logic [SLOT_W-1:0] CURRENT_SLOT,
	// save frame write
	output logic SAVE_VALID,
	output logic [63:0] SAVE_ADDR,
	output aess_pkg::aess_gpr_t SAVE_GPR,
	output aess_pkg::aess_seg_t SAVE_SEG,
	output logic EXT_SAVE_FMT64,
	// restore request on resume
	output logic RESTORE_VALID,
	output logic [63:0] RESTORE_ADDR,
	// synthetic state
	output logic SYNTH_VALID,
	output aess_pkg::aess_gpr_t SYNTH_GPR,
	output aess_pkg::aess_fp_t SYNTH_FP,
	output aess_pkg::aess_seg_t SYNTH_SEG,
	output logic [63:0] SYNTH_FAULT_ADDR
);

	// apply a synthetic value to the low half only in 32-bit mode
	function automatic logic [63:0] apply_mode(
		input logic [63:0] old_val,
		input logic [63:0] new_val,
		input logic mode64
	);
		logic [63:0] res;
		res = mode64 ? new_val : ((old_val & ~aess_pkg::LOW32_MASK) | (new_val & aess_pkg::LOW32_MASK));
		return res;
	endfunction

	// sequencer and slot state
	aess_pkg::aess_state_t state_q;
	logic [SLOT_W-1:0] slot_q;
	// exit context captured when the exit is taken
	aess_pkg::aess_gpr_t gpr_q;
	aess_pkg::aess_cause_t cause_q;
	logic mode64_q;
	logic [63:0] fault_q;
	logic [63:0] tcs_q;
	logic [63:0] aep_q;
	// segment bases as of the last enter or resume
	aess_pkg::aess_seg_t seg_entry_q;

	// frame address lookup
	logic [SLOT_W-1:0] addr_slot;
	logic [63:0] stack_base;
	logic [63:0] frame_addr;
	// request decode
	logic take_exit;
	logic take_resume;
	logic take_enter;
	logic slot_free;
	logic slot_used;
	// synthetic values
	aess_pkg::aess_gpr_t synth_d;
	aess_pkg::aess_fp_t fp_d;
	logic [63:0] fault_d;

	// exit wins over resume, resume over enter; all wait while busy
	assign take_exit = (state_q == aess_pkg::ST_IDLE) && EXIT_REQ;
	assign take_resume = (state_q == aess_pkg::ST_IDLE) && !EXIT_REQ && RESUME_REQ;
	assign take_enter = (state_q == aess_pkg::ST_IDLE) && !EXIT_REQ && !RESUME_REQ && ENTER_REQ;

	assign slot_free = slot_q < SLOT_COUNT;
	// a resume needs a frame that an exit filled
	assign slot_used = slot_q != '0;

	// current slot names the frame
	// resume restores the most recently filled frame, one below current
	assign addr_slot = take_resume ? (slot_q - SLOT_W'(1)) : slot_q;

	// geometry arithmetic kept apart so it can be pipelined later
	aess_frame_addr #(
		.SLOT_W(SLOT_W)
	) u_frame_addr (
		.enclave_base_linear(ENCLAVE_BASE_LINEAR),
		.save_area_offset(SAVE_AREA_OFFSET),
		.frame_size_pages(FRAME_SIZE_PAGES),
		.slot(addr_slot),
		.stack_base(stack_base),
		.frame_addr(frame_addr)
	);

	// sequencer: idle, write frame, load synthetic state
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= aess_pkg::ST_IDLE;
		end else begin
			case (state_q)
				aess_pkg::ST_IDLE: begin
					if (take_exit) begin
						state_q <= aess_pkg::ST_SAVE;
					end
				end
				aess_pkg::ST_SAVE: begin
					state_q <= aess_pkg::ST_SYNTH;
				end
				aess_pkg::ST_SYNTH: begin
					state_q <= aess_pkg::ST_IDLE;
				end
				default: begin
					state_q <= aess_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// busy flag mirrors the sequencer so callers can hold requests
	always_ff @(posedge CLK) begin
		if (SRST) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= take_exit || (state_q == aess_pkg::ST_SAVE);
		end
	end

	// current slot: incremented on the same edge as the synthetic load, freed on resume
	always_ff @(posedge CLK) begin
		if (SRST) begin
			slot_q <= '0;
		end else if (state_q == aess_pkg::ST_SAVE) begin
			slot_q <= slot_q + SLOT_W'(1);
		end else if (take_resume && slot_used) begin
			slot_q <= slot_q - SLOT_W'(1);
		end
	end

	// visible copy of the slot index
	always_ff @(posedge CLK) begin
		if (SRST) begin
			CURRENT_SLOT <= '0;
		end else if (state_q == aess_pkg::ST_SAVE) begin
			CURRENT_SLOT <= slot_q + SLOT_W'(1);
		end else if (take_resume && slot_used) begin
			CURRENT_SLOT <= slot_q - SLOT_W'(1);
		end
	end

	// enter answers: one-cycle pulses
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ENTER_OK <= 1'b0;
			ENTER_FAIL <= 1'b0;
		end else begin
			ENTER_OK <= take_enter && slot_free;
			ENTER_FAIL <= take_enter && !slot_free;
		end
	end

	// resume answers and the restore request
	always_ff @(posedge CLK) begin
		if (SRST) begin
			RESUME_OK <= 1'b0;
			RESUME_FAIL <= 1'b0;
			RESTORE_VALID <= 1'b0;
			RESTORE_ADDR <= aess_pkg::ZERO64;
		end else begin
			RESUME_OK <= take_resume && slot_used;
			RESUME_FAIL <= take_resume && !slot_used;
			RESTORE_VALID <= take_resume && slot_used;
			if (take_resume && slot_used) begin
				RESTORE_ADDR <= frame_addr;
			end
		end
	end

	// segment bases captured on a good enter or resume
	always_ff @(posedge CLK) begin
		if (SRST) begin
			seg_entry_q <= '0;
		end else if ((take_enter && slot_free) || (take_resume && slot_used)) begin
			seg_entry_q <= SEG_IN;
		end
	end

	// exit context latched so live inputs may move during the sequence
	always_ff @(posedge CLK) begin
		if (SRST) begin
			gpr_q <= '0;
			cause_q <= '0;
			mode64_q <= 1'b0;
			fault_q <= aess_pkg::ZERO64;
			tcs_q <= aess_pkg::ZERO64;
			aep_q <= aess_pkg::ZERO64;
		end else if (take_exit) begin
			gpr_q <= GPR_IN;
			cause_q <= EXIT_CAUSE;
			mode64_q <= MODE64;
			fault_q <= FAULT_ADDR_IN;
			tcs_q <= THREAD_CONTROL_STRUCT;
			aep_q <= ASYNC_EXIT_POINTER;
		end
	end

	// frame write, issued the cycle after the exit is taken
	always_ff @(posedge CLK) begin
		if (SRST) begin
			SAVE_VALID <= 1'b0;
			SAVE_ADDR <= aess_pkg::ZERO64;
			SAVE_GPR <= '0;
			SAVE_SEG <= '0;
			EXT_SAVE_FMT64 <= 1'b0;
		end else begin
			SAVE_VALID <= take_exit;
			if (take_exit) begin
				SAVE_ADDR <= frame_addr;
				SAVE_SEG <= SEG_IN;
				EXT_SAVE_FMT64 <= MODE64;
				if (MODE64) begin
					SAVE_GPR <= GPR_IN;
				end else begin
					SAVE_GPR <= GPR_IN & {$bits(aess_pkg::aess_gpr_t)/64{aess_pkg::LOW32_MASK}};
				end
			end
		end
	end

	// synthetic register file built from the latched context
	always_comb begin
		synth_d = gpr_q;
		synth_d.accumulator_reg = apply_mode(gpr_q.accumulator_reg, aess_pkg::RESUME_LEAF, mode64_q);
		synth_d.base_reg = apply_mode(gpr_q.base_reg, tcs_q, mode64_q);
		synth_d.counter_reg = apply_mode(gpr_q.counter_reg, aep_q, mode64_q);
		synth_d.instruction_pointer = apply_mode(gpr_q.instruction_pointer, aep_q, mode64_q);
		synth_d.data_reg = apply_mode(gpr_q.data_reg, aess_pkg::ZERO64, mode64_q);
		synth_d.source_index_reg = apply_mode(gpr_q.source_index_reg, aess_pkg::ZERO64, mode64_q);
		synth_d.dest_index_reg = apply_mode(gpr_q.dest_index_reg, aess_pkg::ZERO64, mode64_q);
		synth_d.stack_pointer_reg = apply_mode(gpr_q.stack_pointer_reg, SAVED_UNTRUSTED_SP, mode64_q);
		synth_d.frame_base_reg = apply_mode(gpr_q.frame_base_reg, SAVED_UNTRUSTED_BP, mode64_q);
		for (int i = 0; i < aess_pkg::NUM_UPPER; i++) begin
			synth_d.upper_general_regs[i] = mode64_q ? aess_pkg::ZERO64 : gpr_q.upper_general_regs[i];
		end
		synth_d.flags_reg = gpr_q.flags_reg & ~aess_pkg::FLAGS_CLEAR_MASK;
	end

	// synthetic floating-point words by exit cause
	always_comb begin
		fp_d.requested_feature_mask = aess_pkg::INIT_FEATURE_MASK;
		fp_d.header_state_vector = aess_pkg::INIT_HEADER_VECTOR;
		fp_d.x87_control_word = cause_q.x87_fp_fault ? aess_pkg::X87_CW_FAULT : aess_pkg::X87_CW_OTHER;
		fp_d.x87_status_word = cause_q.x87_fp_fault ? aess_pkg::X87_SW_FAULT : aess_pkg::X87_SW_OTHER;
		fp_d.simd_ctrl_status = cause_q.simd_fp_fault ? aess_pkg::SIMD_CS_FAULT
			: aess_pkg::SIMD_CS_OTHER;
	end

	// fault address: low 12 bits cleared only when the page fault itself is the exit event
	always_comb begin
		if (cause_q.page_fault && !cause_q.pf_vm_exit && !cause_q.pf_in_delivery) begin
			fault_d = fault_q & aess_pkg::FAULT_LOW_MASK;
		end else begin
			fault_d = fault_q;
		end
	end

	// synthetic state registered on the step after the frame write
	always_ff @(posedge CLK) begin
		if (SRST) begin
			SYNTH_VALID <= 1'b0;
			SYNTH_GPR <= '0;
			SYNTH_FP <= '0;
			SYNTH_SEG <= '0;
			SYNTH_FAULT_ADDR <= aess_pkg::ZERO64;
		end else begin
			SYNTH_VALID <= (state_q == aess_pkg::ST_SAVE);
			if (state_q == aess_pkg::ST_SAVE) begin
				SYNTH_GPR <= synth_d;
				SYNTH_FP <= fp_d;
				SYNTH_SEG <= seg_entry_q;
				SYNTH_FAULT_ADDR <= fault_d;
			end
		end
	end

endmodule // aess_top

// file: testbench/aess_top_sva.sv
`timescale 1ns/100ps
module aess_top_sva #(
	parameter int unsigned SLOT_W = 32
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// commands
	input wire logic ENTER_REQ,
	input wire logic RESUME_REQ,
	input wire logic EXIT_REQ,
	input wire logic [SLOT_W-1:0] SLOT_COUNT,
	// answers
	input wire logic ENTER_OK,
	input wire logic ENTER_FAIL,
	input wire logic RESUME_OK,
	input wire logic RESUME_FAIL,
	input wire logic RESTORE_VALID,
	input wire logic BUSY,
	input wire logic [SLOT_W-1:0] CURRENT_SLOT,
	input wire logic SAVE_VALID,
	input wire logic SYNTH_VALID,
	input wire aess_pkg::aess_gpr_t SYNTH_GPR,
	input wire aess_pkg::aess_fp_t SYNTH_FP
);
	// no exit in flight, so a request is taken
	logic idle;
	assign idle = !BUSY && !SAVE_VALID && !SYNTH_VALID;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	a_exit_seq: assert property (EXIT_REQ && idle |=> SAVE_VALID && BUSY ##1 SYNTH_VALID && BUSY ##1 !BUSY)
		else $error("exit sequence wrong");
	a_slot_step: assert property (SAVE_VALID |=> CURRENT_SLOT == $past(CURRENT_SLOT) + 1)
		else $error("slot not incremented");
	a_enter_room: assert property (ENTER_REQ && !RESUME_REQ && !EXIT_REQ && idle |=>
		ENTER_OK != ENTER_FAIL && ENTER_OK == ($past(CURRENT_SLOT) < $past(SLOT_COUNT)))
		else $error("enter answer wrong");
	a_resume_ans: assert property (RESUME_REQ && !EXIT_REQ && idle |=>
		RESUME_OK == ($past(CURRENT_SLOT) != 0) && RESUME_FAIL == !RESUME_OK
		&& RESTORE_VALID == RESUME_OK)
		else $error("resume answer wrong");
	a_resume_free: assert property (RESUME_OK |-> CURRENT_SLOT == $past(CURRENT_SLOT) - 1)
		else $error("frame not freed");
	a_busy_drop: assert property (BUSY |=> !(ENTER_OK || ENTER_FAIL || RESUME_OK || RESUME_FAIL))
		else $error("request taken while busy");
	a_synth_regs: assert property (SYNTH_VALID |-> SYNTH_GPR.accumulator_reg[31:0] == 32'h3
		&& SYNTH_GPR.data_reg[31:0] == 32'h0 && SYNTH_GPR.dest_index_reg[31:0] == 32'h0)
		else $error("synthetic registers wrong");
	a_synth_flags: assert property (SYNTH_VALID |->
		(SYNTH_GPR.flags_reg & aess_pkg::FLAGS_CLEAR_MASK) == 64'h0)
		else $error("flags not cleared");
	a_synth_fp: assert property (SYNTH_VALID |-> SYNTH_FP.requested_feature_mask == 2'h3
		&& SYNTH_FP.header_state_vector == 2'h0 && SYNTH_FP.x87_control_word[15:1] == 15'h01bf)
		else $error("floating state wrong");
endmodule // aess_top_sva

bind aess_top aess_top_sva #(.SLOT_W(SLOT_W)) u_sva (.CLK, .SRST, .ENTER_REQ, .RESUME_REQ,
	.EXIT_REQ, .SLOT_COUNT, .ENTER_OK, .ENTER_FAIL, .RESUME_OK, .RESUME_FAIL, .RESTORE_VALID,
	.BUSY, .CURRENT_SLOT, .SAVE_VALID, .SYNTH_VALID, .SYNTH_GPR, .SYNTH_FP);

// file: testbench/aess_top_test.sv
`timescale 1ns/100ps
module aess_top_test;
	// clock, reset, geometry
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [63:0] base = 64'h0000_0000_0010_0000;
	// two pages hold a whole frame
	logic [31:0] pages = 32'h0000_0002;
	logic [63:0] offs = 64'h0000_0000_0000_2000;
	logic [31:0] count = 32'h0000_0003;
	logic [63:0] tc_ptr = 64'h0000_7fff_0000_1000;
	logic [63:0] exit_ptr = 64'h0000_7fff_0000_2468;
	// commands and live state
	logic enter_req = 1'b0;
	logic resume_req = 1'b0;
	logic exit_req = 1'b0;
	logic m64 = 1'b1;
	aess_pkg::aess_cause_t cause = '0;
	// upper halves set so a 32-bit exit shows what it keeps
	aess_pkg::aess_gpr_t gpr = {19{64'h8000_0000_ffff_ffff}};
	aess_pkg::aess_seg_t seg = {64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888};
	aess_pkg::aess_seg_t held;
	logic [63:0] fault = 64'hfedc_ba98_7654_3abc;
	logic [63:0] sp_back = 64'h0000_0000_0bad_5000;
	logic [63:0] bp_back = 64'h0000_0000_0bad_6000;
	// outputs
	logic enter_ok, enter_fail, resume_ok, resume_fail, busy, save_valid, ext_fmt64;
	logic restore_valid, synth_valid;
	logic [31:0] cur_slot;
	logic [63:0] save_addr, restore_addr, synth_fault;
	aess_pkg::aess_gpr_t save_gpr, synth_gpr;
	aess_pkg::aess_seg_t save_seg, synth_seg;
	aess_pkg::aess_fp_t synth_fp;
	// bench bookkeeping; slot is the expected current slot
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] slot = '0;

	aess_top u_dut (.CLK(clk), .SRST(srst), .ENCLAVE_BASE_LINEAR(base), .FRAME_SIZE_PAGES(pages),
		.SAVE_AREA_OFFSET(offs), .SLOT_COUNT(count), .THREAD_CONTROL_STRUCT(tc_ptr),
		.ASYNC_EXIT_POINTER(exit_ptr), .ENTER_REQ(enter_req), .RESUME_REQ(resume_req),
		.EXIT_REQ(exit_req), .EXIT_CAUSE(cause), .MODE64(m64), .GPR_IN(gpr), .SEG_IN(seg),
		.FAULT_ADDR_IN(fault), .SAVED_UNTRUSTED_SP(sp_back), .SAVED_UNTRUSTED_BP(bp_back),
		.ENTER_OK(enter_ok), .ENTER_FAIL(enter_fail), .RESUME_OK(resume_ok),
		.RESUME_FAIL(resume_fail), .BUSY(busy), .CURRENT_SLOT(cur_slot),
		.SAVE_VALID(save_valid), .SAVE_ADDR(save_addr), .SAVE_GPR(save_gpr), .SAVE_SEG(save_seg),
		.EXT_SAVE_FMT64(ext_fmt64), .RESTORE_VALID(restore_valid), .RESTORE_ADDR(restore_addr),
		.SYNTH_VALID(synth_valid), .SYNTH_GPR(synth_gpr), .SYNTH_FP(synth_fp),
		.SYNTH_SEG(synth_seg), .SYNTH_FAULT_ADDR(synth_fault));

	// free-running clock
	always #5 clk = ~clk;
	// hang guard, well above the run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			results();
		end
	end

	// compare with four-state equality
	task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// 32-bit mode keeps the upper half
	function automatic logic [63:0] sy(input logic [63:0] old, input logic [63:0] nv);
		return m64 ? nv : {old[63:32], nv[31:0]};
	endfunction
	// frame address of a slot
	function automatic logic [63:0] fa(input logic [31:0] s);
		return base + offs + ((64'(s) * 64'(pages)) << 12);
	endfunction

	// one enter or resume, answer checked a cycle later
	task automatic cmd(input logic is_enter, input logic exp_ok);
		@(posedge clk);
		enter_req <= is_enter;
		resume_req <= !is_enter;
		@(posedge clk);
		enter_req <= 1'b0;
		resume_req <= 1'b0;
		@(negedge clk);
		if (is_enter) begin
			chk("enter_ok", enter_ok, exp_ok);
			chk("enter_fail", enter_fail, !exp_ok);
		end else begin
			chk("resume_ok", resume_ok, exp_ok);
			chk("resume_fail", resume_fail, !exp_ok);
			chk("restore_valid", restore_valid, exp_ok);
			if (exp_ok) begin
				slot--;
				chk("restore_addr", restore_addr, fa(slot));
			end
		end
		// segment bases remembered on success only
		if (exp_ok) held = seg;
		chk("slot", cur_slot, slot);
	endtask

	// one exit; live segments differ from the remembered ones
	task automatic do_exit(input aess_pkg::aess_cause_t c, input logic md);
		logic [63:0] fx;
		@(posedge clk);
		exit_req <= 1'b1;
		cause <= c;
		m64 <= md;
		seg <= ~held;
		@(posedge clk);
		exit_req <= 1'b0;
		@(negedge clk);
		chk("save_valid", save_valid, 1'b1);
		chk("save_addr", save_addr, fa(slot));
		chk("save_acc", save_gpr.accumulator_reg, md ? gpr.accumulator_reg :
			gpr.accumulator_reg & aess_pkg::LOW32_MASK);
		chk("save_seg", save_seg.extra_segment_one, seg.extra_segment_one);
		chk("ext_fmt", ext_fmt64, md);
		@(negedge clk);
		slot++;
		chk("synth_valid", synth_valid, 1'b1);
		chk("slot", cur_slot, slot);
		chk("acc", synth_gpr.accumulator_reg, sy(gpr.accumulator_reg, 64'h3));
		chk("base_reg", synth_gpr.base_reg, sy(gpr.base_reg, tc_ptr));
		chk("counter", synth_gpr.counter_reg, sy(gpr.counter_reg, exit_ptr));
		chk("ip", synth_gpr.instruction_pointer, sy(gpr.instruction_pointer, exit_ptr));
		chk("data", synth_gpr.data_reg, sy(gpr.data_reg, 64'h0));
		chk("src_idx", synth_gpr.source_index_reg, sy(gpr.source_index_reg, 64'h0));
		chk("upper7", synth_gpr.upper_general_regs[7],
			md ? 64'h0 : gpr.upper_general_regs[7]);
		chk("sp", synth_gpr.stack_pointer_reg, sy(gpr.stack_pointer_reg, sp_back));
		chk("bp", synth_gpr.frame_base_reg, sy(gpr.frame_base_reg, bp_back));
		chk("flags", synth_gpr.flags_reg, gpr.flags_reg & ~aess_pkg::FLAGS_CLEAR_MASK);
		chk("x87_cw", synth_fp.x87_control_word, c.x87_fp_fault ? 16'h037e : 16'h037f);
		chk("x87_sw", synth_fp.x87_status_word, c.x87_fp_fault ? 16'h8081 : 16'h0000);
		chk("simd_cs", synth_fp.simd_ctrl_status,
			c.simd_fp_fault ? 32'h0000_1f01 : 32'h0000_1fb0);
		chk("fp_init", {synth_fp.requested_feature_mask, synth_fp.header_state_vector},
			4'hc);
		fx = (c.page_fault && !c.pf_vm_exit && !c.pf_in_delivery) ? fault & 64'hffff_ffff_ffff_f000
			: fault;
		chk("fault_addr", synth_fault, fx);
		chk("seg_two", synth_seg.extra_segment_two, held.extra_segment_two);
	endtask

	// reset state, then resume with no frame filled
	task automatic t_reset();
		@(negedge clk);
		chk("busy", busy, 1'b0);
		chk("slot", cur_slot, 32'h0);
		cmd(1'b0, 1'b0);
		cmd(1'b1, 1'b1);
	endtask
	// every cause, alternating 32 and 64-bit mode
	task automatic t_exits();
		aess_pkg::aess_cause_t tbl [6] = '{5'h10, 5'h08, 5'h04, 5'h06, 5'h05, 5'h00};
		for (int i = 0; i < 6; i++) do_exit(tbl[i], i[0]);
	endtask
	// frees down to the boundary, enter at and below the count
	task automatic t_release();
		repeat (3) cmd(1'b0, 1'b1);
		cmd(1'b1, 1'b0);
		cmd(1'b0, 1'b1);
		cmd(1'b1, 1'b1);
	endtask
	// enter with the exit and during busy is dropped
	task automatic t_busy();
		@(posedge clk);
		exit_req <= 1'b1;
		enter_req <= 1'b1;
		@(posedge clk);
		exit_req <= 1'b0;
		@(negedge clk);
		chk("enter_drop", enter_ok | enter_fail, 1'b0);
		@(posedge clk);
		enter_req <= 1'b0;
		@(negedge clk);
		slot++;
		chk("enter_busy", enter_ok | enter_fail, 1'b0);
		chk("slot", cur_slot, slot);
	endtask

	// counts and verdict
	task automatic results();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		held = seg;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_exits();
		t_release();
		t_busy();
		results();
	end
endmodule // aess_top_test
